// [phy_ctrl_map.svh]
`ifndef PHY_CTRL_MAP_SVH
`define PHY_CTRL_MAP_SVH

// Register addresses
`define REG_ADDR_W        5
`define REG_BASIC_CONTROL 5'h00
`define REG_STD_LAST      5'h0F
`define REG_VENDOR_FIRST  5'h10

// Basic control field positions
`define BC_SW_RESET       15
`define BC_LOOPBACK       14
`define BC_SPEED_LSB      13
`define BC_AN_ENABLE      12
`define BC_POWER_DOWN     11
`define BC_ISOLATE        10
`define BC_AN_RESTART     9
`define BC_DUPLEX         8
`define BC_COL_TEST       7
`define BC_SPEED_MSB      6

// Reset value, write mask and strap width
`define BC_RESET_VALUE    16'h1100
`define BC_WRITE_MASK     16'hFFC0
`define MODE_W            4

// Speed encodings of {msb, lsb}
`define SPEED_10          2'h0
`define SPEED_100         2'h1
`define SPEED_1000        2'h2
`define SPEED_RSVD        2'h3

// Length of the internal soft reset pulse in cycles
`define SW_RESET_CYCLES   4'hF

`endif

// [phy_ctrl_pkg.sv]
package phy_ctrl_pkg;

    typedef enum logic [1:0] {
        SPD_10_TYPE,
        SPD_100_TYPE,
        SPD_1000_TYPE,
        SPD_RSVD_TYPE
    } speed_type;

    typedef struct packed {
        logic      loopback;
        logic      power_down;
        logic      isolate;
        logic      col_test;
        logic      an_enable;
        logic      full_duplex;
        speed_type speed;
    } ctrl_type;

    typedef struct packed {
        logic       an_done;
        logic       full_duplex;
        speed_type  speed;
    } an_result_type;

endpackage : phy_ctrl_pkg

// [strap_sync.sv]
`include "phy_ctrl_map.svh"

// Two-stage synchroniser for the asynchronous mode straps
module strap_sync (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    // Pins in, synchronised out
    input  wire logic [`MODE_W-1:0]    mode_pin,
    output logic      [`MODE_W-1:0]    mode_sync
);

    logic [`MODE_W-1:0] meta_r;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r    <= '0;
            mode_sync <= '0;
        end else begin
            meta_r    <= mode_pin;
            mode_sync <= meta_r;
        end
    end

endmodule : strap_sync

// [phy_basic_control_regs.sv]
// Overview of operation
// - Addresses 0 to 31 are decoded; only register 0 is readable and writable, the rest read zero and ignore writes.
// - Addresses 0 to 15 follow the standard layout; 16 to 31 are vendor space.
// - Writing one to bit 15 starts a soft reset; bit self-clears, default zero.
// - Bit 12 enables auto-negotiation; resets to one.
// - Negotiation overrides speed and duplex; otherwise {bit6,bit13} select speed.
// - Bit 6 resets from the mode straps; bit 13 resets to zero.
// - Writing one to bit 9 restarts negotiation if bit 12 is already set; bit self-clears, default zero.
// - Bit 10 isolates the device from the MAC data interface; default zero.
// - Bit 7 enables the collision signal test; default zero.
`include "phy_ctrl_map.svh"

module phy_basic_control_regs (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    // Management access, one-cycle strobes
    input  wire logic [`REG_ADDR_W-1:0]        reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [15:0]                   reg_wdata,
    output logic      [15:0]                   reg_rdata,
    output logic                               reg_rvalid,
    // Strap pins
    input  wire logic [`MODE_W-1:0]            mode_pin,
    // Negotiation result from the link engine
    input  wire phy_ctrl_pkg::an_result_type   an_result,
    // Control to the rest of the transceiver
    output phy_ctrl_pkg::ctrl_type             ctrl_out,
    output logic                               an_restart_pulse,
    output logic                               soft_reset_out,
    output logic                               mac_if_enable
);

    // ****************************************************
    // Strap capture
    // ****************************************************
    logic [`MODE_W-1:0] mode_sync;
    logic [1:0]         strap_cnt_r;
    logic               strap_done_r;

    strap_sync u_strap_sync (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .mode_pin  (mode_pin),
        .mode_sync (mode_sync)
    );

    // Straps are caught after the synchroniser has filled, never under reset
    wire strap_load = !strap_done_r && (strap_cnt_r == 2'h2);
    // Any 1000-capable mode strap (top strap bit) sets the speed msb
    wire strap_speed_msb = mode_sync[`MODE_W-1];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_cnt_r  <= strap_cnt_r + 2'h1;
            strap_done_r <= strap_load;
        end
    end

    // ****************************************************
    // Basic control register
    // ****************************************************
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic        strap_msb_r;
    logic [3:0]  rst_cnt_r;

    wire sel_ctrl  = (reg_addr == `REG_BASIC_CONTROL);
    wire wr_ctrl   = reg_wr && sel_ctrl;
    wire rst_pulse = (rst_cnt_r != 4'h0);
    // A soft reset reloads defaults, keeping the strapped speed msb
    wire [15:0] defaults = `BC_RESET_VALUE | ({15'h0, strap_msb_r} << `BC_SPEED_MSB);
    wire [15:0] wr_val   = reg_wdata & `BC_WRITE_MASK;

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (strap_load) begin
            ctrl_nxt[`BC_SPEED_MSB] = strap_speed_msb;
        end
        if (rst_cnt_r == 4'h1) begin
            ctrl_nxt = defaults;
        end else if (wr_ctrl && !rst_pulse) begin
            ctrl_nxt = wr_val;
        end
        // Self-clearing bits are never stored, so a back-to-back read cannot catch them
        ctrl_nxt[`BC_SW_RESET]   = 1'b0;
        ctrl_nxt[`BC_AN_RESTART] = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r      <= `BC_RESET_VALUE;
            strap_msb_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (strap_load) begin
                strap_msb_r <= strap_speed_msb;
            end
        end
    end

    // Soft reset stretch; writes during it are dropped
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_cnt_r <= 4'h0;
        end else if (wr_ctrl && !rst_pulse && reg_wdata[`BC_SW_RESET]) begin
            rst_cnt_r <= `SW_RESET_CYCLES;
        end else if (rst_pulse) begin
            rst_cnt_r <= rst_cnt_r - 4'h1;
        end
    end

    // ****************************************************
    // Effective mode
    // ****************************************************
    wire [1:0] man_speed = {ctrl_r[`BC_SPEED_MSB], ctrl_r[`BC_SPEED_LSB]};
    wire       an_on     = ctrl_r[`BC_AN_ENABLE];
    wire phy_ctrl_pkg::speed_type eff_speed = an_on ? an_result.speed
                                            : phy_ctrl_pkg::speed_type'(man_speed);
    wire       eff_duplex = an_on ? an_result.full_duplex : ctrl_r[`BC_DUPLEX];
    wire restart_req = wr_ctrl && !rst_pulse && reg_wdata[`BC_AN_RESTART];

    phy_ctrl_pkg::ctrl_type ctrl_nxt_s;
    always_comb begin
        ctrl_nxt_s.loopback    = ctrl_r[`BC_LOOPBACK];
        ctrl_nxt_s.power_down  = ctrl_r[`BC_POWER_DOWN];
        ctrl_nxt_s.isolate     = ctrl_r[`BC_ISOLATE];
        ctrl_nxt_s.col_test    = ctrl_r[`BC_COL_TEST];
        ctrl_nxt_s.an_enable   = an_on;
        ctrl_nxt_s.full_duplex = eff_duplex;
        ctrl_nxt_s.speed       = eff_speed;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_out         <= '0;
            an_restart_pulse <= 1'b0;
            soft_reset_out   <= 1'b0;
            mac_if_enable    <= 1'b0;
        end else begin
            ctrl_out         <= ctrl_nxt_s;
            an_restart_pulse <= restart_req && an_on;
            soft_reset_out   <= rst_pulse;
            mac_if_enable    <= !ctrl_r[`BC_ISOLATE] && !rst_pulse;
        end
    end

    // ****************************************************
    // Read path
    // ****************************************************
    // Only register 0 lives here; the rest of the space reads zero
    wire        std_space = (reg_addr <= `REG_STD_LAST);
    wire [15:0] rd_mux    = (sel_ctrl && std_space) ? ctrl_r : 16'h0000;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

endmodule : phy_basic_control_regs

// [phy_basic_control_regs_properties.sv]
module phy_ctrl_checker (
    // Clock and reset
    input wire logic                        sys_clk,
    input wire logic                        resetn,
    // Management access
    input wire logic [4:0]                  reg_addr,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [15:0]                 reg_wdata,
    input wire logic [15:0]                 reg_rdata,
    input wire logic                        reg_rvalid,
    // Control side
    input wire phy_ctrl_pkg::an_result_type an_result,
    input wire phy_ctrl_pkg::ctrl_type      ctrl_out,
    input wire logic                        an_restart_pulse,
    input wire logic                        soft_reset_out,
    input wire logic                        mac_if_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Writes land only outside a running soft reset; the output lags the
    // internal busy window by a cycle, so the window is modelled here
    logic [3:0] busy_cnt_r;
    wire ctl_wr = reg_wr && reg_addr == 5'h00 && busy_cnt_r == 4'h0;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy_cnt_r <= 4'h0;
        end else if (ctl_wr && reg_wdata[15]) begin
            busy_cnt_r <= 4'hF;
        end else if (busy_cnt_r != 4'h0) begin
            busy_cnt_r <= busy_cnt_r - 4'h1;
        end
    end
    sequence s_launch; ctl_wr && reg_wdata[15]; endsequence
    sequence s_hold; soft_reset_out [*8] ##1 soft_reset_out [*7] ##1 !soft_reset_out; endsequence
    property p_soft_reset; s_launch |=> ##1 s_hold; endproperty
    property p_rvalid; reg_rd |=> reg_rvalid; endproperty
    property p_rvalid_cause; reg_rvalid |-> $past(reg_rd); endproperty
    property p_rdata_zero; reg_rvalid |-> reg_rdata[15] == 1'b0 && reg_rdata[9] == 1'b0 && reg_rdata[5:0] == 6'h00; endproperty
    property p_vendor; reg_rd && reg_addr != 5'h00 |=> reg_rdata == 16'h0000; endproperty
    property p_restart; ctl_wr && reg_wdata[9] |=> an_restart_pulse == ctrl_out.an_enable; endproperty
    property p_restart_cause; an_restart_pulse |-> $past(ctl_wr) && $past(reg_wdata[9]); endproperty
    property p_an_override; $stable(an_result) && ctrl_out.an_enable |-> ctrl_out.speed == an_result.speed && ctrl_out.full_duplex == an_result.full_duplex; endproperty
    property p_isolate; ctrl_out.isolate |-> !mac_if_enable; endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset length wrong");
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray read valid");
    a_rdata_zero: assert property (p_rdata_zero) else $error("cleared bits read one");
    a_vendor: assert property (p_vendor) else $error("unused address reads nonzero");
    a_restart: assert property (p_restart) else $error("restart pulse missing");
    a_restart_cause: assert property (p_restart_cause) else $error("stray restart pulse");
    a_an_override: assert property (p_an_override) else $error("negotiated mode ignored");
    a_isolate: assert property (p_isolate) else $error("mac side not isolated");
endmodule : phy_ctrl_checker
bind phy_basic_control_regs phy_ctrl_checker chk_u (.sys_clk, .resetn, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .an_result, .ctrl_out, .an_restart_pulse,
    .soft_reset_out, .mac_if_enable);

// [mgmt_master_model.sv]
module mgmt_master_model (
    // Clock
    input wire logic         sys_clk,
    // Management access
    output logic [4:0]       reg_addr = 5'h00,
    output logic             reg_wr = 1'b0,
    output logic             reg_rd = 1'b0,
    output logic [15:0]      reg_wdata = 16'h0000,
    input wire logic [15:0]  reg_rdata,
    input wire logic         reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge sys_clk);
        reg_wr    = 1'b0;
        // Data inverted once released, so a late capture shows up
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge sys_clk);
        reg_rd   = 1'b0;
        d        = reg_rvalid ? reg_rdata : 16'hXXXX;
    endtask : rd
endmodule : mgmt_master_model

// [tb_phy_basic_control_regs.sv]
module tb_phy_basic_control_regs;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [15:0]            wdata;
        logic [15:0]            rdata;
        phy_ctrl_pkg::ctrl_type ctrl;
    } row_type;
    logic                        sys_clk = 1'b0;
    logic                        resetn = 1'b0;
    logic [3:0]                  mode_pin = 4'h8;
    phy_ctrl_pkg::an_result_type an_result = 4'h9;
    wire [4:0]                   reg_addr;
    wire [15:0]                  reg_wdata;
    wire                         reg_wr, reg_rd;
    logic [15:0]                 reg_rdata;
    logic                        reg_rvalid, an_restart_pulse, soft_reset_out, mac_if_enable;
    phy_ctrl_pkg::ctrl_type      ctrl_out;
    int                          errors = 0;
    int                          samples_checked = 0;
    int                          cycles = 0;
    row_type rows [6] = '{'{16'h4000, 16'h4000, 8'h80}, '{16'h2000, 16'h2000, 8'h01},
        '{16'h0040, 16'h0040, 8'h02}, '{16'h2040, 16'h2040, 8'h03},
        '{16'h0DBF, 16'h0D80, 8'h74}, '{16'h1100, 16'h1100, 8'h09}};
    always #20 sys_clk = ~sys_clk;
    mgmt_master_model mst_u (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid);
    phy_basic_control_regs dut_u (.sys_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .reg_rvalid, .mode_pin, .an_result, .ctrl_out, .an_restart_pulse,
        .soft_reset_out, .mac_if_enable);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    // ****************
    // Reset and vendor checks, table, then hand-written cases
    // ****************
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        logic [15:0] v;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (5) @(negedge sys_clk);
        mst_u.rd(5'h00, v);
        check(v, 16'h1140);
        check({8'h00, ctrl_out}, 16'h0009);
        mst_u.wr(5'h13, 16'hFFFF);
        mst_u.rd(5'h13, v);
        check(v, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            mst_u.wr(5'h00, rows[i].wdata);
            mst_u.rd(5'h00, v);
            check(v, rows[i].rdata);
            check({8'h00, ctrl_out}, {8'h00, rows[i].ctrl});
            check({15'h0000, mac_if_enable}, {15'h0000, !rows[i].ctrl.isolate});
        end
        // A new negotiated result must follow through while negotiation is on
        @(negedge sys_clk);
        an_result = 4'hE;
        repeat (2) @(negedge sys_clk);
        check({8'h00, ctrl_out}, 16'h000E);
        mst_u.wr(5'h00, 16'h1300);
        check({15'h0000, an_restart_pulse}, 16'h0001);
        mst_u.rd(5'h00, v);
        check(v, 16'h1100);
        // Second write lands inside the soft reset and must be dropped
        mst_u.wr(5'h00, 16'h8000);
        @(negedge sys_clk);
        check({15'h0000, soft_reset_out}, 16'h0001);
        mst_u.wr(5'h00, 16'h4000);
        // The 0x8000 write cleared every writable bit; the dropped write must not show
        mst_u.rd(5'h00, v);
        check(v, 16'h0000);
        repeat (16) @(negedge sys_clk);
        check({15'h0000, soft_reset_out}, 16'h0000);
        mst_u.rd(5'h00, v);
        check(v, 16'h1140);
        tally_and_finish();
    end
endmodule : tb_phy_basic_control_regs
